// ===== dgc_host.sv
module dgc_host (
  input wire logic core_clk,
  input wire logic serial_data_out,
  input wire logic serial_data_oe,
  output logic chan_a_select_n = 1'b1,
  output logic chan_b_select_n = 1'b1,
  output logic serial_clk = 1'b0,
  output wire logic serial_data_in
);
  logic drv = 1'b0;
  logic bit_q = 1'b0;
  logic pat_q = 1'b0;
  // A released line toggles every cycle so a stale bit is never read.
  assign serial_data_in = serial_data_oe ? serial_data_out : (drv ? bit_q : pat_q);
  always @(posedge core_clk) begin
    pat_q <= ~pat_q;
  end
  task automatic xfer(input logic a_n, input logic b_n, input logic wr, input logic [15:0] w,
                      output logic [15:0] r);
    @(posedge core_clk);
    chan_a_select_n <= a_n;
    chan_b_select_n <= b_n;
    drv <= wr;
    repeat (4) @(posedge core_clk);
    for (int i = 15; i >= 0; i--) begin
      serial_clk <= 1'b0;
      bit_q <= w[i];
      repeat (3) @(posedge core_clk);
      serial_clk <= 1'b1;
      repeat (4) @(posedge core_clk);
      #1 r[i] = serial_data_in;
      @(posedge core_clk);
    end
    serial_clk <= 1'b0;
    repeat (4) @(posedge core_clk);
    chan_a_select_n <= 1'b1;
    chan_b_select_n <= 1'b1;
    drv <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// ===== dgc_pkg.sv
package dgc_pkg;

  typedef enum {MODE_PARALLEL, MODE_SERIAL, MODE_UPDOWN} dgc_mode_e;

  localparam int CODE_W = 6;
  localparam int WORD_W = 16;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] WORD_BITS = 5'h10;

  // Serial word layout, shifted in most significant bit first.
  localparam int GAIN_LSB = 0;
  localparam int QA_SEL0_BIT = 6;
  localparam int QA_SEL1_BIT = 7;
  localparam int READ_REQ_BIT = 8;

  localparam logic [CODE_W-1:0] CODE_MAX_GAIN = 6'h00;
  localparam logic [CODE_W-1:0] CODE_MIN_GAIN = 6'h3f;
  localparam logic [CODE_W-1:0] CODE_LAST_STEP = 6'h23;
  localparam logic [CODE_W-1:0] GAIN_TOP_DB = 6'h1a;
  localparam logic [CODE_W-1:0] GAIN_FLOOR_DB = 6'h37;
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;

  // Step sizes in code units for step-size pins 00, 01, 10, 11.
  localparam logic [CODE_W-1:0] STEP_SEL0 = 6'h01;
  localparam logic [CODE_W-1:0] STEP_SEL1 = 6'h02;
  localparam logic [CODE_W-1:0] STEP_SEL2 = 6'h03;
  localparam logic [CODE_W-1:0] STEP_SEL3 = 6'h04;

  typedef struct packed {
    logic powered;
    logic low_power;
    logic quick_atten;
    logic [1:0] atten_sel;
    logic [CODE_W-1:0] code;
    logic [CODE_W-1:0] gain_db;
  } dgc_chan_s;

  function automatic dgc_mode_e dgc_mode(input logic hi, input logic lo);
    if (hi) begin
      return MODE_UPDOWN;
    end
    return lo ? MODE_SERIAL : MODE_PARALLEL;
  endfunction

  // Gain in dB as two's complement, floored above the last step code.
  function automatic logic [CODE_W-1:0] dgc_gain_db(input logic [CODE_W-1:0] code);
    if (code > CODE_LAST_STEP) begin
      return GAIN_FLOOR_DB;
    end
    return GAIN_TOP_DB - code;
  endfunction

  function automatic logic [CODE_W-1:0] dgc_step(input logic [1:0] sel);
    case (sel)
      2'b01: return STEP_SEL1;
      2'b10: return STEP_SEL2;
      2'b11: return STEP_SEL3;
      default: return STEP_SEL0;
    endcase
  endfunction

endpackage

// ===== dgc_top.sv
module dgc_top
  import dgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic iface_select_hi,
  input wire logic iface_select_lo,
  input wire logic power_profile_sel,
  input wire logic chan_a_power_on,
  input wire logic chan_b_power_on,
  input wire logic chan_a_hold,
  input wire logic chan_b_hold,
  input wire logic [CODE_W-1:0] chan_a_gain_code,
  input wire logic [CODE_W-1:0] chan_b_gain_code,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic serial_clk,
  input wire logic serial_data_in,
  output logic serial_data_out,
  output logic serial_data_oe,
  input wire logic chan_a_quick_atten,
  input wire logic chan_b_quick_atten,
  input wire logic chan_a_step_strobe,
  input wire logic chan_b_step_strobe,
  input wire logic chan_a_step_direction,
  input wire logic chan_b_step_direction,
  input wire logic step_size_sel1,
  input wire logic step_size_sel0,
  output dgc_chan_s chan_a_status,
  output dgc_chan_s chan_b_status
);

  localparam int SYNC_W = 31;

  // Synchroniser reset value: every pin at its idle level, both selects high.
  // A zero here would make the selects look low, then rise, right after reset.
  // That false edge would reach the serial edge detectors.
  localparam logic [SYNC_W-1:0] PINS_IDLE = 31'h0000_0c00;

  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_m_q;
  logic [SYNC_W-1:0] pins_s_q;

  // All pins travel as one bus through the synchroniser.
  // The order here must match the unpacking below, most significant first.
  assign pins_raw = {
    iface_select_hi,
    iface_select_lo,
    power_profile_sel,
    chan_b_power_on,
    chan_a_power_on,
    chan_b_hold,
    chan_a_hold,
    chan_b_gain_code,
    chan_a_gain_code,
    chan_b_select_n,
    chan_a_select_n,
    serial_clk,
    serial_data_in,
    chan_b_quick_atten,
    chan_a_quick_atten,
    chan_b_step_strobe,
    chan_a_step_strobe,
    chan_b_step_direction,
    chan_a_step_direction,
    step_size_sel1,
    step_size_sel0
  };

  // Every pin passes two flip-flops before any logic looks at it.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pins_m_q <= PINS_IDLE;
      pins_s_q <= PINS_IDLE;
    end else if (clk_en) begin
      pins_m_q <= pins_raw;
      pins_s_q <= pins_m_q;
    end
  end

  // Synchronised pin levels; index 0 of each per-channel pair is channel A, and gs_s[0] is step_size_sel0.
  logic mode_hi_s;
  logic mode_lo_s;
  logic profile_s;
  logic sclk_s;
  logic sdi_s;
  logic [1:0] power_s;
  logic [1:0] hold_s;
  logic [1:0] sel_n_s;
  logic [1:0] qa_s;
  logic [1:0] strobe_s;
  logic [1:0] dir_s;
  logic [1:0] gs_s;
  logic [CODE_W-1:0] code_in_s [2];

  assign {
    mode_hi_s,
    mode_lo_s,
    profile_s,
    power_s,
    hold_s,
    code_in_s[1],
    code_in_s[0],
    sel_n_s,
    sclk_s,
    sdi_s,
    qa_s,
    strobe_s,
    dir_s,
    gs_s
  } = pins_s_q;

  // The interface and the step size are decoded from synchronised levels only.
  // A mode change therefore takes effect two clocks after the pins move.

  dgc_mode_e mode;
  logic [CODE_W-1:0] step;

  assign mode = dgc_mode(mode_hi_s, mode_lo_s);
  assign step = dgc_step(gs_s);

  // Edge detection on the synchronised serial pins.
  logic sclk_p_q;
  logic [1:0] sel_n_p_q;
  logic sclk_rise;
  logic cycle_start;
  logic [1:0] sel_fall;
  logic [1:0] sel_rise;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_p_q <= 1'b0;
      sel_n_p_q <= 2'b11;
    end else if (clk_en) begin
      sclk_p_q <= sclk_s;
      sel_n_p_q <= sel_n_s;
    end
  end

  // Edges are one clock wide and seen two clocks after the pin moves.
  // A cycle starts only when the first select falls from the all-idle state.
  assign sclk_rise = sclk_s & ~sclk_p_q;
  assign sel_fall = sel_n_p_q & ~sel_n_s;
  assign sel_rise = ~sel_n_p_q & sel_n_s;
  assign cycle_start = (&sel_n_p_q) & ~(&sel_n_s);

  // Serial state. The bit counter tells a complete frame from a cut or long one.
  // Read state is kept per channel, but only one channel can be read at a time.
  logic [WORD_W-1:0] shift_in_q;
  logic [CNT_W-1:0] bit_cnt_q;
  logic [1:0] reading_q;
  logic [1:0] read_pend_q;
  logic [WORD_W-1:0] shift_out_q;
  logic [WORD_W-1:0] word [2];
  logic [1:0] load_en;

  // Write shifter shared by both channels, so both selects low load one word.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_in_q <= WORD_RESET;
      bit_cnt_q <= '0;
    end else if (clk_en) begin
      if (cycle_start) begin
        bit_cnt_q <= '0;
      end else if (sclk_rise && !(&sel_n_s) && !(|reading_q)) begin
        shift_in_q <= {shift_in_q[WORD_W-2:0], sdi_s};
        // Counting one past the word length lets an overlong frame be refused.
        if (bit_cnt_q <= WORD_BITS) begin
          bit_cnt_q <= bit_cnt_q + 5'h01;
        end
      end
    end
  end

  // Read-back: armed by a write with the read request set, used by one cycle.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      reading_q <= 2'b00;
      read_pend_q <= 2'b00;
      shift_out_q <= WORD_RESET;
      serial_data_out <= 1'b0;
      serial_data_oe <= 1'b0;
    end else if (clk_en) begin
      // A read needs the other select high, since the data line is shared.
      // With both selects low the cycle is taken as a write instead.
      for (int i = 0; i < 2; i++) begin
        if (sel_fall[i] && sel_n_s[1-i] && read_pend_q[i] && mode == MODE_SERIAL) begin
          reading_q[i] <= 1'b1;
          shift_out_q <= word[i];
        end else if (sel_rise[i] && reading_q[i]) begin
          reading_q[i] <= 1'b0;
          read_pend_q[i] <= 1'b0;
        end else if (load_en[i]) begin
          read_pend_q[i] <= shift_in_q[READ_REQ_BIT];
        end
      end
      if (|reading_q && sclk_rise) begin
        serial_data_out <= shift_out_q[WORD_W-1];
        shift_out_q <= {shift_out_q[WORD_W-2:0], 1'b0};
      end
      // The driver is released as soon as the select rises, ending the read.
      serial_data_oe <= |reading_q && !(&sel_n_s);
    end
  end

  // Per-channel logic: stored serial word, gain code and registered status.
  // The two channels share the serial shifter, the read-back shifter, the mode, the step size and the power profile pin.
  dgc_chan_s status [2];

  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [WORD_W-1:0] word_q;
      logic [CODE_W-1:0] code_q;
      logic strobe_p_q;
      logic dir_rise_q;
      logic strobe_rise;
      logic strobe_fall;
      logic [CODE_W:0] sum;
      dgc_chan_s status_q;

      assign word[ch] = word_q;

      // A word is taken only at the end of a complete write frame.
      // The read cycle never loads, so reading does not disturb the stored word.
      assign load_en[ch] = sel_rise[ch] && !reading_q[ch] && mode == MODE_SERIAL
                           && bit_cnt_q == WORD_BITS;
      assign strobe_rise = strobe_s[ch] & ~strobe_p_q;
      assign strobe_fall = ~strobe_s[ch] & strobe_p_q;
      // The extra bit of the sum shows an overflow past the lowest gain.
      assign sum = {1'b0, code_q} + {1'b0, step};

      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          word_q <= WORD_RESET;
        end else if (clk_en && load_en[ch]) begin
          word_q <= shift_in_q;
        end
      end

      // The direction is captured at every strobe rise, in any mode.
      // It is compared with the level at the fall to spot a reset pattern.
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          strobe_p_q <= 1'b0;
          dir_rise_q <= 1'b0;
        end else if (clk_en) begin
          strobe_p_q <= strobe_s[ch];
          if (strobe_rise) begin
            dir_rise_q <= dir_s[ch];
          end
        end
      end

      // The code is kept regardless of the power-on pin.
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          code_q <= CODE_MAX_GAIN;
        end else if (clk_en) begin
          case (mode)
            MODE_PARALLEL: begin
              if (!hold_s[ch]) begin
                code_q <= code_in_s[ch];
              end
            end
            MODE_SERIAL: begin
              if (load_en[ch]) begin
                code_q <= shift_in_q[GAIN_LSB +: CODE_W];
              end
            end
            MODE_UPDOWN: begin
              // A step is applied only at the fall, so a full pulse is needed.
              // Both ends clamp rather than wrap.
              if (strobe_fall) begin
                if (dir_rise_q != dir_s[ch]) begin
                  code_q <= CODE_MIN_GAIN;
                end else if (!dir_s[ch]) begin
                  code_q <= (code_q > step) ? code_q - step : CODE_MAX_GAIN;
                end else begin
                  code_q <= sum[CODE_W] ? CODE_MIN_GAIN : sum[CODE_W-1:0];
                end
              end
            end
            default: begin
              code_q <= code_q;
            end
          endcase
        end
      end

      // Status is registered so every output of the block comes from a flop.
      // It lags the internal code by one clock.
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          status_q <= '0;
        end else if (clk_en) begin
          status_q.powered <= power_s[ch];
          status_q.low_power <= profile_s;
          status_q.quick_atten <= qa_s[ch] && mode == MODE_SERIAL;
          status_q.atten_sel <= {word_q[QA_SEL1_BIT], word_q[QA_SEL0_BIT]};
          status_q.code <= code_q;
          status_q.gain_db <= dgc_gain_db(code_q);
        end
      end

      assign status[ch] = status_q;
    end
  endgenerate

  // Channel A is index 0, channel B index 1.
  assign chan_a_status = status[0];
  assign chan_b_status = status[1];

endmodule

// ===== dgc_top_bench.sv
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module dgc_top_bench
  import dgc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 0, reset_n = 0, clk_en = 1, iface_select_hi = 0, iface_select_lo = 0;
  logic power_profile_sel = 0, chan_a_power_on = 1, chan_b_power_on = 1, chan_a_hold = 0;
  logic chan_b_hold = 0, chan_a_quick_atten = 0, chan_b_quick_atten = 0;
  logic step_size_sel1 = 0, step_size_sel0 = 0, chan_a_step_strobe = 0, chan_b_step_strobe = 0;
  logic chan_a_step_direction = 0, chan_b_step_direction = 0;
  logic [5:0] chan_a_gain_code = 6'h05, chan_b_gain_code = 6'h28, exp_code;
  logic chan_a_select_n, chan_b_select_n, serial_clk, serial_data_in, serial_data_out, serial_data_oe;
  logic [15:0] rd;
  dgc_chan_s chan_a_status, chan_b_status;
  int error_cnt = 0, check_count = 0;
  dgc_top dut (.*);
  dgc_host host (.*);
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic strobe(input logic d1, input logic d2);
    chan_a_step_direction <= d1;
    tick(4);
    chan_a_step_strobe <= 1'b1;
    tick(4);
    chan_a_step_direction <= d2;
    tick(4);
    chan_a_step_strobe <= 1'b0;
    look(10);
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #400us;
    error_cnt++;
    conclude();
  end
  initial begin
    tick(6);
    reset_n <= 1'b1;
    look(10);
    `CHK("a code", 6'h05, chan_a_status.code)
    `CHK("a gain", 6'h15, chan_a_status.gain_db)
    `CHK("b gain", 6'h37, chan_b_status.gain_db)
    tick(1);
    chan_a_hold <= 1'b1;
    chan_b_gain_code <= 6'h22;
    tick(6);
    chan_a_gain_code <= 6'h21;
    look(8);
    `CHK("a held", 6'h05, chan_a_status.code)
    `CHK("b gain", 6'h38, chan_b_status.gain_db)
    tick(1);
    iface_select_lo <= 1'b1;
    tick(6);
    host.xfer(1'b0, 1'b0, 1'b1, 16'h014a, rd);
    host.xfer(1'b0, 1'b1, 1'b0, 16'h0000, rd);
    `CHK("read", 16'h014a, rd)
    host.xfer(1'b0, 1'b1, 1'b1, 16'h0011, rd);
    `CHK("no read", 16'h0011, rd)
    chan_a_quick_atten <= 1'b1;
    chan_b_power_on <= 1'b0;
    power_profile_sel <= 1'b1;
    look(8);
    `CHK("quick", 1'b1, chan_a_status.quick_atten)
    `CHK("atten", 2'b00, chan_a_status.atten_sel)
    `CHK("b atten", 2'b01, chan_b_status.atten_sel)
    `CHK("b quick", 1'b0, chan_b_status.quick_atten)
    `CHK("b sleep", 1'b0, chan_b_status.powered)
    `CHK("low pwr", 1'b1, chan_a_status.low_power)
    tick(1);
    chan_a_quick_atten <= 1'b0;
    chan_b_power_on <= 1'b1;
    iface_select_hi <= 1'b1;
    iface_select_lo <= 1'b0;
    look(8);
    `CHK("b code", 6'h0a, chan_b_status.code)
    `CHK("b on", 1'b1, chan_b_status.powered)
    exp_code = 6'h11;
    for (int s = 0; s < 4; s++) begin
      tick(1);
      {step_size_sel1, step_size_sel0} <= 2'(s);
      exp_code = exp_code - 6'(s + 1);
      strobe(1'b0, 1'b0);
      `CHK("step", exp_code, chan_a_status.code)
    end
    tick(1);
    strobe(1'b1, 1'b1);
    `CHK("down", 6'h0b, chan_a_status.code)
    tick(1);
    strobe(1'b0, 1'b1);
    `CHK("reset", 6'h3f, chan_a_status.code)
    tick(1);
    strobe(1'b1, 1'b1);
    `CHK("rail", 6'h3f, chan_a_status.code)
    tick(1);
    iface_select_lo <= 1'b1;
    {step_size_sel1, step_size_sel0} <= 2'b01;
    tick(6);
    strobe(1'b0, 1'b0);
    `CHK("mode 11", 6'h3d, chan_a_status.code)
    tick(1);
    clk_en <= 1'b0;
    strobe(1'b0, 1'b0);
    clk_en <= 1'b1;
    look(6);
    `CHK("frozen", 6'h3d, chan_a_status.code)
    conclude();
  end
endmodule

// ===== dgc_top_chk.sv
module dgc_top_chk
  import dgc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic iface_select_hi,
  input wire logic iface_select_lo,
  input wire logic power_profile_sel,
  input wire logic chan_a_power_on,
  input wire logic chan_a_hold,
  input wire logic chan_a_select_n,
  input wire logic chan_b_select_n,
  input wire logic chan_a_quick_atten,
  input wire logic serial_data_oe,
  input wire dgc_chan_s chan_a_status,
  input wire dgc_chan_s chan_b_status
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);
  sequence sel_idle;
    (chan_a_select_n && chan_b_select_n) [*8];
  endsequence
  a_oe_one_sel: assert property ($rose(serial_data_oe) |-> chan_a_select_n != chan_b_select_n)
    else $error("oe rose without one select");
  a_oe_idle: assert property (sel_idle |-> !serial_data_oe)
    else $error("oe high while idle");
  a_oe_serial: assert property (serial_data_oe |-> iface_select_lo && !iface_select_hi)
    else $error("oe outside serial mode");
  a_gain_floor: assert property (chan_b_status.code > 6'h23 |-> chan_b_status.gain_db == 6'h37)
    else $error("gain not floored");
  a_gain_slope: assert property (chan_a_status.code inside {[6'h01:6'h23]}
    |-> chan_a_status.gain_db == 6'h1a - chan_a_status.code)
    else $error("gain slope wrong");
  a_power_on: assert property (chan_a_power_on [*8] |-> chan_a_status.powered)
    else $error("channel not powered");
  a_low_power: assert property (power_profile_sel [*8] |-> chan_a_status.low_power)
    else $error("low power not shown");
  a_latch_hold: assert property ((!iface_select_hi && !iface_select_lo && chan_a_hold) [*8]
    |-> $stable(chan_a_status.code))
    else $error("held code moved");
  a_quick_off: assert property ((!chan_a_quick_atten) [*8] |-> !chan_a_status.quick_atten)
    else $error("quick atten without pin");
endmodule
bind dgc_top dgc_top_chk chk (.*);
